// *** rtl/ldm_regs.sv ***
`timescale 1ns/1ns
`include "ldm_defines.svh"

// Function
// R01 - Page supplies address bits 23 to 16
// R02 - Page value never moves by itself
// R03 - Page ports 87,83,81,82,8B,89,8A read/write
// R04 - Command bit 4 picks fixed or rotating
// R05 - Reset leaves both groups fixed priority
// R06 - Command bit 2 disables group, reset enabled
// R07 - Upper group disable also stops lower group
// R08 - Software writes zero to reserved bits
// R09 - Writes reach command, reads return status
// R10 - Status 7:4 show pending valid requests
// R11 - Cascade channel request is OR of lower
// R12 - Status 3:0 set on terminal count
// R13 - Cascade channel terminal count is meaningless
// R14 - Mask bit 2 masks, clear unmasks one
// R15 - Mask bits 1:0 select the channel
// R16 - Mask ports 0A and D4, default masked
// R17 - Master clear restores reset state
// R18 - Wide channels shift address left once
// R19 - Status read clears terminal count flags

module ldm_regs #(
  parameter int ADDR_W = 16,
  parameter int PAGE_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [7:0]        ioAddr,
  input  wire logic              ioWr,
  input  wire logic              ioRd,
  input  wire logic [7:0]        ioWrData,
  input  wire logic [7:0][15:0]  curAddr,
  input  wire logic [7:0]        hwReq,
  input  wire logic [7:0]        swReq,
  input  wire logic [7:0]        tcIn,
  input  wire logic              masterClearLo,
  input  wire logic              masterClearHi,
  output logic [7:0]             ioRdData,
  output logic                   ioRdAck,
  output logic [7:0][23:0]       xferAddr,
  output logic [7:0]             chanMask,
  output logic [1:0]             groupRun,
  output logic [1:0]             rotatePri
);

  if (ADDR_W != 16 || PAGE_W != 8) begin : g_check
    $error("ldm_regs serves only a 16-bit current address and an 8-bit page");
  end

  // Returns {hit, slot}; the cascade slot 4 has no page port and never decodes
  function automatic logic [3:0] pageSlot(input logic [7:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a == `LDM_PORT_PAGE0) begin
      r = 4'h8;
    end else if (a == `LDM_PORT_PAGE1) begin
      r = 4'h9;
    end else if (a == `LDM_PORT_PAGE2) begin
      r = 4'hA;
    end else if (a == `LDM_PORT_PAGE3) begin
      r = 4'hB;
    end else if (a == `LDM_PORT_PAGE5) begin
      r = 4'hD;
    end else if (a == `LDM_PORT_PAGE6) begin
      r = 4'hE;
    end else if (a == `LDM_PORT_PAGE7) begin
      r = 4'hF;
    end
    return r;  // R03
  endfunction

  ldm_pkg::ldm_top_s s;
  ldm_pkg::ldm_top_s next_s;

  logic [3:0] wrSlot;
  logic [3:0] rdSlot;
  logic       cmdWrLo;
  logic       cmdWrHi;
  logic       maskWrLo;
  logic       maskWrHi;
  logic       staRdLo;
  logic       staRdHi;
  logic       disLo;
  logic       disHi;
  logic       rotLo;
  logic       rotHi;
  logic [3:0] maskLo;
  logic [3:0] maskHi;
  logic [7:0] statusLo;
  logic [7:0] statusHi;
  logic [3:0] loReqNow;
  logic       cascReq;

  assign wrSlot   = pageSlot(ioAddr);
  assign rdSlot   = pageSlot(ioAddr);
  // Shared port: the write direction hits command, the read direction status
  assign cmdWrLo  = ioWr && ioAddr == `LDM_PORT_CMD_LO;  // R09
  assign cmdWrHi  = ioWr && ioAddr == `LDM_PORT_CMD_HI;  // R09
  assign staRdLo  = ioRd && ioAddr == `LDM_PORT_CMD_LO;  // R09
  assign staRdHi  = ioRd && ioAddr == `LDM_PORT_CMD_HI;  // R09
  assign maskWrLo = ioWr && ioAddr == `LDM_PORT_MASK_LO;  // R16
  assign maskWrHi = ioWr && ioAddr == `LDM_PORT_MASK_HI;  // R16

  // Same term the lower group latches, so both status bytes move together
  assign loReqNow = (hwReq[3:0] & ~maskLo) | swReq[3:0];
  assign cascReq  = |loReqNow;  // R11

  ldm_group #(
    .CASCADE (1'b0)
  ) u_grpLo (
    .clk      (clk),
    .rst      (rst),
    .cmdWr    (cmdWrLo),
    .maskWr   (maskWrLo),
    .statusRd (staRdLo),
    .clearAll (masterClearLo),
    .wrData   (ioWrData),
    .hwReq    (hwReq[3:0]),
    .swReq    (swReq[3:0]),
    .cascReq  (1'b0),
    .tcIn     (tcIn[3:0]),
    .rotate   (rotLo),
    .disabled (disLo),
    .mask     (maskLo),
    .status   (statusLo)
  );

  // Channel 4 terminal count is tied off; its status bit has no meaning
  ldm_group #(
    .CASCADE (1'b1)
  ) u_grpHi (
    .clk      (clk),
    .rst      (rst),
    .cmdWr    (cmdWrHi),
    .maskWr   (maskWrHi),
    .statusRd (staRdHi),
    .clearAll (masterClearHi),
    .wrData   (ioWrData),
    .hwReq    (hwReq[7:4]),
    .swReq    (swReq[7:4]),
    .cascReq  (cascReq),
    .tcIn     ({tcIn[7:5], 1'b0}),  // R13
    .rotate   (rotHi),
    .disabled (disHi),
    .mask     (maskHi),
    .status   (statusHi)
  );

  always_comb begin
    next_s = s;
    if (ioWr && wrSlot[3]) begin
      next_s.page[wrSlot[2:0]] = ioWrData;  // R03
    end
    // Full address for each channel except cascade channel 4, which stays zero; the page only changes by a port write
    for (int ch = 0; ch < 8; ch++) begin
      if (ch == `LDM_CASCADE_CH) begin
        next_s.xfer[ch] = 24'h000000;
      end else if (ch >= `LDM_WIDE_CH_FIRST) begin
        // Word channels lose address bit 15 to the shift
        next_s.xfer[ch] = {s.page[ch], curAddr[ch][14:0], 1'b0};  // R18
      end else begin
        next_s.xfer[ch] = {s.page[ch], curAddr[ch]};  // R01 R02
      end
    end
    next_s.rdAck = ioRd;
    if (!ioRd) begin
      next_s.rdData = s.rdData;
    end else if (rdSlot[3]) begin
      next_s.rdData = s.page[rdSlot[2:0]];
    end else if (ioAddr == `LDM_PORT_CMD_LO) begin
      next_s.rdData = statusLo;  // R10 R12
    end else if (ioAddr == `LDM_PORT_CMD_HI) begin
      next_s.rdData = statusHi;  // R10 R11
    end else begin
      // Write-only and foreign ports float high, as an undriven bus would
      next_s.rdData = `LDM_FLOAT_DATA;
    end
    // The lower group only reaches the bus through cascade channel 4
    next_s.run[1] = !disHi;  // R06
    next_s.run[0] = !disLo && !disHi;  // R07
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '{page: {8{`LDM_PAGE_RST}}, xfer: '0, rdData: `LDM_FLOAT_DATA,
             rdAck: 1'b0, run: 2'b11};
    end else begin
      s <= next_s;
    end
  end

  assign ioRdData  = s.rdData;
  assign ioRdAck   = s.rdAck;
  assign xferAddr  = s.xfer;
  assign groupRun  = s.run;
  assign chanMask  = {maskHi, maskLo};
  assign rotatePri = {rotHi, rotLo};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence pageWrite0;
    ioWr && ioAddr == `LDM_PORT_PAGE0;
  endsequence

  sequence pageRead0;
    ioRd && ioAddr == `LDM_PORT_PAGE0;
  endsequence

  sequence statusReadLo;
    ioRd && ioAddr == `LDM_PORT_CMD_LO;
  endsequence

  sequence statusReadHi;
    ioRd && ioAddr == `LDM_PORT_CMD_HI;
  endsequence

  sequence maskWriteLo;
    maskWrLo && !masterClearLo;
  endsequence

  sequence maskWriteHi;
    maskWrHi && !masterClearHi;
  endsequence

  // An idle cycle between write and read-back keeps the written byte in place
  pageWrRd_a: assert property (pageWrite0 ##1 !ioWr ##1 pageRead0 |=>  // R03
      ioRdAck && ioRdData == $past(ioWrData, 3))
    else $error("page register did not return the written byte");

  pageHold_a: assert property (!(ioWr && ioAddr == `LDM_PORT_PAGE1) ##1 1'b1 |->  // R02
      xferAddr[1][23:16] == $past(xferAddr[1][23:16]) || $past(ioWr, 2))
    else $error("page bits moved without a port write");

  addrJoin_a: assert property (1'b1 |=>  // R01
      xferAddr[2] == {$past(s.page[2]), $past(curAddr[2])})
    else $error("narrow channel address not joined with its page");

  wideShift_a: assert property (1'b1 |=>  // R18
      xferAddr[6] == {$past(s.page[6]), $past(curAddr[6][14:0]), 1'b0})
    else $error("word channel address not shifted");

  // A master clear empties one group's requests only, so those cycles are exempt
  cascadeReq_a: assert property (!masterClearLo && !masterClearHi |=>  // R11
      statusHi[4] == |statusLo[7:4])
    else $error("cascade request differs from lower group requests");

  upperStops_a: assert property (disHi |=> groupRun == 2'b00)  // R07
    else $error("lower group kept running with upper group disabled");

  statusRead_a: assert property (statusReadLo |=>  // R09
      ioRdAck && ioRdData == $past(statusLo))
    else $error("status read returned wrong byte");

  maskReset_a: assert property ($rose(masterClearHi) |=> chanMask[7:4] == 4'hF)  // R16
    else $error("upper masks not set by master clear");

  reqStatus_a: assert property (swReq[2] && !masterClearLo |=> statusLo[6])  // R10
    else $error("software request not shown in status");

  rotSelect_a: assert property (cmdWrHi && !masterClearHi |=>  // R04
      rotatePri[1] == $past(ioWrData[4]))
    else $error("upper group priority scheme not taken");

  floatRead_a: assert property (ioRd && ioAddr == `LDM_PORT_MASK_LO |=>  // R16
      ioRdData == `LDM_FLOAT_DATA)
    else $error("write-only mask port did not float on read");

  readAck_a: assert property (ioRd |=> ioRdAck)  // R09
    else $error("read strobe not acknowledged");

  ackPulse_a: assert property (!ioRd |=> !ioRdAck)  // R09
    else $error("read acknowledge without a read");

  rdDataHold_a: assert property (!ioRd |=> $stable(ioRdData))  // R09
    else $error("read data moved between reads");

  statusHi_a: assert property (statusReadHi |=> ioRdAck && ioRdData == $past(statusHi))  // R09
    else $error("upper status read returned wrong byte");

  floatHi_a: assert property (ioRd && ioAddr == `LDM_PORT_MASK_HI |=>  // R16
      ioRdData == `LDM_FLOAT_DATA)
    else $error("upper mask port did not float on read");

  addrJoin0_a: assert property (1'b1 |=>  // R01
      xferAddr[0] == {$past(s.page[0]), $past(curAddr[0])})
    else $error("channel 0 address not joined with its page");

  addrJoin1_a: assert property (1'b1 |=>  // R01
      xferAddr[1] == {$past(s.page[1]), $past(curAddr[1])})
    else $error("channel 1 address not joined with its page");

  addrJoin3_a: assert property (1'b1 |=>  // R01
      xferAddr[3] == {$past(s.page[3]), $past(curAddr[3])})
    else $error("channel 3 address not joined with its page");

  wideShift5_a: assert property (1'b1 |=>  // R18
      xferAddr[5] == {$past(s.page[5]), $past(curAddr[5][14:0]), 1'b0})
    else $error("channel 5 address not shifted");

  wideShift7_a: assert property (1'b1 |=>  // R18
      xferAddr[7] == {$past(s.page[7]), $past(curAddr[7][14:0]), 1'b0})
    else $error("channel 7 address not shifted");

  upperRuns_a: assert property (!disHi |=> groupRun[1])  // R06
    else $error("upper group stopped while enabled");

  lowerRuns_a: assert property (!disLo && !disHi |=> groupRun[0])  // R07
    else $error("lower group stopped while both groups enabled");

  lowerStops_a: assert property (disLo |=> !groupRun[0])  // R06
    else $error("lower group kept running while disabled");

  rotLoSelect_a: assert property (cmdWrLo && !masterClearLo |=>  // R04
      rotatePri[0] == $past(ioWrData[4]))
    else $error("lower group priority scheme not taken");

  maskSelLo_a: assert property (maskWriteLo |=>  // R14 R15
      maskLo[$past(ioWrData[1:0])] == $past(ioWrData[2]))
    else $error("lower single mask write not taken");

  maskSelHi_a: assert property (maskWriteHi |=>  // R14 R15
      maskHi[$past(ioWrData[1:0])] == $past(ioWrData[2]))
    else $error("upper single mask write not taken");

  maskClrLo_a: assert property (masterClearLo |=> chanMask[3:0] == 4'hF)  // R17
    else $error("lower masks not set by master clear");

  staClrLo_a: assert property (masterClearLo |=> statusLo == 8'h00)  // R17
    else $error("lower status not cleared by master clear");

  staClrHi_a: assert property (masterClearHi |=> statusHi == 8'h00)  // R17
    else $error("upper status not cleared by master clear");

  reqMasked_a: assert property (hwReq[1] && chanMask[1] && !swReq[1] &&  // R10
      !masterClearLo |=> !statusLo[5])
    else $error("masked hardware request shown in status");

  runClrHi_a: assert property (masterClearHi |-> ##2 groupRun[1])  // R17
    else $error("upper group not enabled after master clear");

  runClrLo_a: assert property (masterClearLo ##1 !disHi |=> groupRun[0])  // R17
    else $error("lower group not enabled after master clear");

endmodule

// *** rtl/ldm_defines.svh ***
`ifndef LDM_DEFINES_SVH
`define LDM_DEFINES_SVH

// I/O port decode, lower group (channels 0-3)
`define LDM_PORT_CMD_LO   8'h08
`define LDM_PORT_MASK_LO  8'h0A
// I/O port decode, upper group (channels 4-7)
`define LDM_PORT_CMD_HI   8'hD0
`define LDM_PORT_MASK_HI  8'hD4
// Page register ports
`define LDM_PORT_PAGE0    8'h87
`define LDM_PORT_PAGE1    8'h83
`define LDM_PORT_PAGE2    8'h81
`define LDM_PORT_PAGE3    8'h82
`define LDM_PORT_PAGE5    8'h8B
`define LDM_PORT_PAGE6    8'h89
`define LDM_PORT_PAGE7    8'h8A

// Command register fields
`define LDM_CMD_ROT_BIT   4
`define LDM_CMD_DIS_BIT   2
// Single-mask register fields
`define LDM_SMSK_SET_BIT  2
`define LDM_SMSK_SEL_HI   1
`define LDM_SMSK_SEL_LO   0
// Status register fields
`define LDM_STA_REQ_LSB   4
`define LDM_STA_TC_LSB    0

// Reset values
`define LDM_MASK_RST      4'hF
`define LDM_TC_RST        4'h0
`define LDM_REQ_RST       4'h0
`define LDM_PAGE_RST      8'h00
`define LDM_FLOAT_DATA    8'hFF

// Channel layout
`define LDM_CASCADE_CH    4
`define LDM_WIDE_CH_FIRST 5

`endif

// *** rtl/ldm_pkg.sv ***
package ldm_pkg;

  typedef logic [7:0] ldm_byte_t;

  typedef struct packed {
    logic       rotate;
    logic       disabled;
    logic [3:0] mask;
    logic [3:0] tc;
    logic [3:0] req;
  } ldm_grp_s;

  typedef struct packed {
    logic [7:0][7:0]  page;
    logic [7:0][23:0] xfer;
    ldm_byte_t        rdData;
    logic             rdAck;
    logic [1:0]       run;
  } ldm_top_s;

endpackage

// *** rtl/ldm_group.sv ***
`timescale 1ns/1ns
`include "ldm_defines.svh"

module ldm_group #(
  parameter bit CASCADE = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cmdWr,
  input  wire logic       maskWr,
  input  wire logic       statusRd,
  input  wire logic       clearAll,
  input  wire logic [7:0] wrData,
  input  wire logic [3:0] hwReq,
  input  wire logic [3:0] swReq,
  input  wire logic       cascReq,
  input  wire logic [3:0] tcIn,
  output logic            rotate,
  output logic            disabled,
  output logic [3:0]      mask,
  output logic [7:0]      status
);

  ldm_pkg::ldm_grp_s s;
  ldm_pkg::ldm_grp_s next_s;
  logic [3:0]        reqNow;

  always_comb begin
    reqNow = (hwReq & ~s.mask) | swReq;  // R10
    if (CASCADE) begin
      reqNow[0] = cascReq;  // R11
    end
    next_s = s;
    if (cmdWr) begin
      next_s.rotate   = wrData[`LDM_CMD_ROT_BIT];  // R04
      next_s.disabled = wrData[`LDM_CMD_DIS_BIT];  // R06
    end
    if (maskWr) begin
      next_s.mask[wrData[`LDM_SMSK_SEL_HI:`LDM_SMSK_SEL_LO]] = wrData[`LDM_SMSK_SET_BIT];  // R14 R15
    end
    next_s.req = reqNow;
    if (statusRd) begin
      next_s.tc = `LDM_TC_RST;  // R19
    end
    // A terminal count landing on the clearing read is kept for the next read
    next_s.tc = next_s.tc | tcIn;  // R12
    if (clearAll) begin
      next_s.rotate   = 1'b0;  // R17
      next_s.disabled = 1'b0;
      next_s.mask     = `LDM_MASK_RST;
      next_s.tc       = `LDM_TC_RST;
      next_s.req      = `LDM_REQ_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '{rotate: 1'b0, disabled: 1'b0, mask: `LDM_MASK_RST,
             tc: `LDM_TC_RST, req: `LDM_REQ_RST};  // R05 R06 R16
    end else begin
      s <= next_s;
    end
  end

  assign rotate   = s.rotate;
  assign disabled = s.disabled;
  assign mask     = s.mask;
  assign status   = {s.req, s.tc};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence maskWrite;
    maskWr && !clearAll;
  endsequence

  maskOnly_a: assert property (maskWrite |=> mask[$past(wrData[1:0])] == $past(wrData[2]) &&  // R14
      ((mask ^ $past(mask)) & ~(4'h1 << $past(wrData[1:0]))) == 4'h0)
    else $error("single mask write touched the wrong channel");
  tcSetWins_a: assert property (tcIn[1] && statusRd && !clearAll |=> status[1])  // R12
    else $error("terminal count lost on clearing read");
  tcClearRead_a: assert property (statusRd && tcIn == 4'h0 && !clearAll |=> status[3:0] == 4'h0)  // R19
    else $error("status read did not clear terminal counts");
  clearState_a: assert property (clearAll |=> mask == 4'hF && !disabled && !rotate)  // R17
    else $error("master clear did not restore defaults");
  cmdFields_a: assert property (cmdWr && !clearAll |=>  // R04
      rotate == $past(wrData[4]) && disabled == $past(wrData[2]))
    else $error("command write not taken");

endmodule

// *** sim/ldm_periph.sv ***
`timescale 1ns/1ns

// Peripheral side: request lines and terminal count pulses follow the
// bench's commands at the next rising edge, as a real device lags its cause.
// Updating on that edge by non-blocking assignment avoids racing the bench,
// which changes its commands on the falling edge.
module ldm_periph (
  input  wire logic       clk,
  input  wire logic [7:0] reqSet,
  input  wire logic [7:0] tcSet,
  output logic      [7:0] hwReq,
  output logic      [7:0] tcIn
);
  initial begin
    hwReq = 8'h00;
    tcIn  = 8'h00;
  end
  always @(posedge clk) begin
    hwReq <= reqSet;
    tcIn  <= tcSet;
  end
endmodule

// *** sim/ldm_regs_tb_top.sv ***
`timescale 1ns/1ns

module ldm_regs_tb_top;
  typedef struct packed {
    logic [7:0] port;
    logic [2:0] ch;
    logic [7:0] val;
  } ldm_row_s;

  logic             clk;
  logic             rst;
  logic             ioWr;
  logic             ioRd;
  logic [7:0]       ioAddr;
  logic [7:0]       ioWrData;
  logic [7:0]       swReq;
  logic [7:0]       reqSet;
  logic [7:0]       tcSet;
  logic [7:0]       hwReq;
  logic [7:0]       tcIn;
  logic [7:0]       ioRdData;
  logic [7:0]       chanMask;
  logic [7:0]       expMask;
  logic [7:0]       rd;
  logic [7:0][15:0] curAddr;
  logic [7:0][23:0] xferAddr;
  logic             masterClearLo;
  logic             masterClearHi;
  logic             ioRdAck;
  logic [1:0]       groupRun;
  logic [1:0]       rotatePri;
  int               mismatches = 0;
  int               total_checks = 0;
  int               cycles = 0;
  ldm_row_s         rows [7] = '{'{8'h87, 3'd0, 8'h5A}, '{8'h83, 3'd1, 8'hA5},
                                 '{8'h81, 3'd2, 8'h3C}, '{8'h82, 3'd3, 8'hC3},
                                 '{8'h8B, 3'd5, 8'hFF}, '{8'h89, 3'd6, 8'h01},
                                 '{8'h8A, 3'd7, 8'h80}};
  // Port, data, expected run, expected rotate
  logic [23:0]      cmds [6] = '{24'h081031, 24'hD01403, 24'hD01033,
                                 24'h080422, 24'h080032, 24'hD00030};

  ldm_regs dut (.clk(clk), .rst(rst), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioWrData(ioWrData), .curAddr(curAddr), .hwReq(hwReq), .swReq(swReq),
    .tcIn(tcIn), .masterClearLo(masterClearLo), .masterClearHi(masterClearHi),
    .ioRdData(ioRdData), .ioRdAck(ioRdAck), .xferAddr(xferAddr),
    .chanMask(chanMask), .groupRun(groupRun), .rotatePri(rotatePri));
  ldm_periph peer (.clk(clk), .reqSet(reqSet), .tcSet(tcSet), .hwReq(hwReq),
    .tcIn(tcIn));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reserved bits are always sent as zero by the callers
  task automatic ioWrite(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWr = 1'b1;
    @(negedge clk);
    ioWr = 1'b0;
  endtask

  task automatic ioRead(input logic [7:0] a);
    @(negedge clk);
    ioAddr = a;
    ioRd = 1'b1;
    @(negedge clk);
    ioRd = 1'b0;
    rd = ioRdData;
    check("read ack", 24'h1, ioRdAck);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    {rst, ioWr, ioRd, ioAddr, ioWrData, swReq, reqSet, tcSet} = '0;
    {masterClearLo, masterClearHi} = 2'b00;
    // Bit 15 set everywhere so its loss on wide channels is visible
    for (int i = 0; i < 8; i++) curAddr[i] = 16'h8000 | (16'h0111 * i);
    rst = 1'b1;
    settle(8);
    rst = 1'b0;
    settle(1);
    check("mask rst", 24'hFF, chanMask);
    check("run rst", 24'h3, groupRun);
    check("rot rst", 24'h0, rotatePri);
    ioRead(8'h08);
    check("sta rst", 24'h00, rd);
    ioRead(8'h0A);
    check("mask rd", 24'hFF, rd);
    ioRead(8'h85);
    check("unmapped", 24'hFF, rd);
    for (int i = 0; i < 7; i++) begin
      ioWrite(rows[i].port, rows[i].val);
      ioRead(rows[i].port);
      check("page", rows[i].val, rd);
      if (rows[i].ch >= 3'd5)
        check("xfer", {rows[i].val, curAddr[rows[i].ch][14:0], 1'b0}, xferAddr[rows[i].ch]);
      else
        check("xfer", {rows[i].val, curAddr[rows[i].ch]}, xferAddr[rows[i].ch]);
    end
    for (int i = 0; i < 8; i++) curAddr[i] = curAddr[i] + 16'h0001;
    settle(2);
    for (int i = 0; i < 7; i++) check("page hold", rows[i].val, xferAddr[rows[i].ch][23:16]);
    check("casc xfer", 24'h0, xferAddr[4]);
    expMask = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      ioWrite(i < 4 ? 8'h0A : 8'hD4, {6'h00, i[1:0]});
      expMask[i] = 1'b0;
      settle(2);
      check("unmask", expMask, chanMask);
    end
    ioWrite(8'h0A, 8'h05);
    expMask[1] = 1'b1;
    settle(2);
    check("mask one", expMask, chanMask);
    reqSet = 8'h22;
    swReq = 8'h04;
    settle(3);
    ioRead(8'h08);
    check("req lo", 24'h40, rd);
    ioRead(8'hD0);
    check("req hi", 24'h30, rd);
    reqSet = 8'h00;
    swReq = 8'h00;
    settle(3);
    ioRead(8'hD0);
    check("req idle", 24'h00, rd);
    tcSet = 8'h24;
    settle(1);
    tcSet = 8'h00;
    settle(3);
    ioRead(8'h08);
    check("tc lo", 24'h04, rd);
    ioRead(8'h08);
    check("tc clr", 24'h00, rd);
    ioRead(8'hD0);
    check("tc hi", 24'h02, rd);
    // Terminal count arriving on the very edge of a clearing read
    tcSet = 8'h02;
    ioRead(8'h08);
    tcSet = 8'h00;
    check("tc race", 24'h00, rd);
    ioRead(8'h08);
    check("tc kept", 24'h02, rd);
    for (int i = 0; i < 6; i++) begin
      ioWrite(cmds[i][23:16], cmds[i][15:8]);
      settle(2);
      check("run", cmds[i][5:4], groupRun);
      check("rot", cmds[i][1:0], rotatePri);
    end
    ioWrite(8'h08, 8'h14);
    masterClearLo = 1'b1;
    settle(1);
    masterClearLo = 1'b0;
    settle(2);
    check("clr mask", {expMask[7:4], 4'hF}, chanMask);
    check("clr rot", 24'h0, rotatePri);
    check("clr run lo", 24'h3, groupRun);
    masterClearHi = 1'b1;
    settle(1);
    masterClearHi = 1'b0;
    settle(2);
    check("clr all", 24'hFF, chanMask);
    check("clr run", 24'h3, groupRun);
    // Second reset in mid-run must drop programmed pages and priority
    ioWrite(8'hD0, 8'h10);
    rst = 1'b1;
    settle(2);
    rst = 1'b0;
    settle(1);
    check("rot rst2", 24'h0, rotatePri);
    ioRead(8'h87);
    check("page rst", 24'h00, rd);
    report_and_stop();
  end
endmodule
